//--- verilog/uid_cfg.svh
/*
  Timing, zone geometry and calibration constants of the input decoder.
  Assumes a 100 MHz clock and a 1 ms tick.
*/
`ifndef UID_CFG_SVH
`define UID_CFG_SVH

`define UID_CLK_PERIOD_NS   10
`define UID_TICK_US         1000
`define UID_TICK_CYCLES     ((`UID_TICK_US * 1000) / `UID_CLK_PERIOD_NS)

`define UID_LONG_PRESS_MS   300
`define UID_VLONG_PRESS_MS  2000
`define UID_DCLICK_MS       500
`define UID_REPEAT_MS       250
`define UID_BLINK_MS        500
`define UID_STEP_GAP_MS     500
`define UID_LONG_TICKS      ((`UID_LONG_PRESS_MS * 1000) / `UID_TICK_US)
`define UID_VLONG_TICKS     ((`UID_VLONG_PRESS_MS * 1000) / `UID_TICK_US)
`define UID_DCLICK_TICKS    ((`UID_DCLICK_MS * 1000) / `UID_TICK_US)
`define UID_REPEAT_TICKS    ((`UID_REPEAT_MS * 1000) / `UID_TICK_US)
`define UID_BLINK_TICKS     ((`UID_BLINK_MS * 1000) / `UID_TICK_US)
`define UID_STEP_GAP_TICKS  ((`UID_STEP_GAP_MS * 1000) / `UID_TICK_US)

`define UID_DB_CHANNELS     5
`define UID_DB_TICKS        2'h3

`define UID_VEL_FAST_TH     18'h000f0
`define UID_VEL_MID_TH      18'h003c0

`define UID_SCR_CHARS       16
`define UID_SCR_LINES       8
`define UID_CHAR_W_PX       8
`define UID_LINE_H_PX       16
`define UID_EDGE_CHARS      3
`define UID_EDGE_LINES      2
`define UID_SCR_W_PX        (`UID_SCR_CHARS * `UID_CHAR_W_PX)
`define UID_SCR_H_PX        (`UID_SCR_LINES * `UID_LINE_H_PX)

`define UID_CAL_ATTEMPTS    2'h3

`endif

//--- verilog/uid_pkg.sv
/*
  Types of the input decoder: grades, wait modes, states.
  Assumes constants come from uid_cfg.svh.
*/
package uid_pkg;

  typedef enum logic [1:0] {
    UID_GRADE_LOW  = 2'h0,
    UID_GRADE_MID  = 2'h1,
    UID_GRADE_HIGH = 2'h2
  } uid_grade_t;

  typedef enum logic [1:0] {
    UID_WAIT_NONE   = 2'h0,
    UID_WAIT_MORE   = 2'h1,
    UID_WAIT_RESUME = 2'h2
  } uid_wait_t;

  typedef enum logic [3:0] {
    UID_K_IDLE  = 4'h1,
    UID_K_DOWN  = 4'h2,
    UID_K_GAP   = 4'h4,
    UID_K_DOWN2 = 4'h8
  } uid_key_st_t;

  typedef enum logic [5:0] {
    UID_C_IDLE = 6'h01,
    UID_C_PT1  = 6'h02,
    UID_C_RAW1 = 6'h04,
    UID_C_PT2  = 6'h08,
    UID_C_RAW2 = 6'h10,
    UID_C_EVAL = 6'h20
  } uid_cal_st_t;

endpackage

//--- verilog/uid_debounce.sv
/*
  Synchroniser and tick debouncer, one lane per input.
  Assumes a one-cycle tick pulse; inputs active high.
*/
`timescale 1ns/1ps
`include "uid_cfg.svh"

module uid_debounce
  import uid_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        tick,
  input  wire logic [`UID_DB_CHANNELS-1:0] raw,
  output logic      [`UID_DB_CHANNELS-1:0] clean
);

  genvar gi;
  generate
    for (gi = 0; gi < `UID_DB_CHANNELS; gi++) begin : g_lane
      logic       sync1_r;
      logic       sync2_r;
      logic [1:0] cnt_r;
      logic       clean_r;

      // New level must hold for several ticks
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          cnt_r   <= 2'h0;
          clean_r <= 1'b0;
        end else begin
          sync1_r <= raw[gi];
          sync2_r <= sync1_r;
          if (sync2_r == clean_r) begin
            cnt_r <= 2'h0;
          end else if (tick) begin
            if (cnt_r == `UID_DB_TICKS - 2'h1) begin
              clean_r <= sync2_r;
              cnt_r   <= 2'h0;
            end else begin
              cnt_r <= cnt_r + 2'h1;
            end
          end
        end
      end

      assign clean[gi] = clean_r;
    end
  endgenerate

endmodule

//--- verilog/uid_top.sv
/*
  User input decoder: key classes, encoder, hold buttons, touch bars,
  touch calibration.
  Assumes pre-scaled synchronous touch coordinates and menu-side judging.
*/
`timescale 1ns/1ps
`include "uid_cfg.svh"

// Operation
// (R01) Short and long key presses reported apart
// (R02) Two quick short presses give double click
// (R03) Steady, blinking or no cursor while waiting
// (R04) Step after configured count of same-direction pulses
// (R05) More detents per turn lowers velocity
// (R06) Velocity from gap between consecutive steps
// (R07) High grade after three fast steps only; code gives it on the second fast step in a row
// (R08) Direction follows phase order of channels
// (R09) Active-low increase/decrease buttons give steps
// (R10) Held button keeps raising speed grade
// (R11) Edge zones three chars, two lines
// (R12) Left/top decrement, right/bottom increment
// (R13) Held edge touch raises speed grade
// (R14) Centre touch acts as key, no hardware
// (R15) Calibrate at power-up without stored values
// (R16) Marker top right then bottom left
// (R17) At most three calibration attempts
// (R18) Physical key press aborts calibration
// (R19) Origin top left, flip and rotate options
// (R20) Inputs synchronised and debounced
// (R21) Two-second press at power-up reported
module uid_top
  import uid_pkg::*;
#(
  parameter int TICK_CYCLES = `UID_TICK_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       test_key,
  input  wire logic       enc_a,
  input  wire logic       enc_b,
  input  wire logic       inc_btn_n,
  input  wire logic       dec_btn_n,
  input  wire logic [2:0] enc_pulses,
  input  wire logic [7:0] enc_steps,
  input  wire logic       touch_valid,
  input  wire logic [7:0] touch_x,
  input  wire logic [7:0] touch_y,
  input  wire logic       touch_flip_x,
  input  wire logic       touch_flip_y,
  input  wire logic       touch_rotate,
  input  wire logic       cal_stored,
  input  wire logic       cal_start,
  input  wire logic       cal_check_valid,
  input  wire logic       cal_check_ok,
  input  wire logic       wait_key,
  input  wire uid_wait_t  wait_mode,
  input  wire logic       show_key_hint_text,
  input  wire logic       key_hint_avail,
  output logic            key_short,
  output logic            key_long,
  output logic            key_double,
  output logic            key_vlong,
  output logic            key_hw_pressed,
  output logic            step_up,
  output logic            step_down,
  output uid_grade_t      speed_grade,
  output logic            cursor_on,
  output logic            key_hint_on,
  output logic            cal_active,
  output logic            marker_top_right,
  output logic            marker_bottom_left,
  output logic            raw_show,
  output logic [7:0]      raw_x,
  output logic [7:0]      raw_y,
  output logic            cal_done,
  output logic            cal_fail,
  output logic            cal_abort
);

  // ----------------------------------------------------------------
  // Time base and input conditioning
  // ----------------------------------------------------------------
  logic [16:0] tick_cnt_r;
  logic        tick;
  logic [4:0]  db_raw;
  logic [4:0]  db;
  logic        key_db;
  logic        key_db_q_r;
  logic        key_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 17'h0;
    end else if (tick) begin
      tick_cnt_r <= 17'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h1;
    end
  end
  assign tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));

  // Pull-up buttons inverted before sync
  assign db_raw = {~dec_btn_n, ~inc_btn_n, enc_b, enc_a, test_key}; // R09

  uid_debounce u_db ( // R20
    .clk   (clk),
    .rst   (rst),
    .tick  (tick),
    .raw   (db_raw),
    .clean (db)
  );
  assign key_db = db[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_db_q_r <= 1'b0;
    end else begin
      key_db_q_r <= key_db;
    end
  end
  assign key_rise = key_db & ~key_db_q_r;
  // Physical key only powers hardware
  assign key_hw_pressed = key_db_q_r; // R14

  // ----------------------------------------------------------------
  // Touch orientation and zones
  // ----------------------------------------------------------------
  logic [7:0] tx_r;
  logic [7:0] ty_r;
  logic       tvalid_r;
  logic       tvalid_q_r;
  logic [7:0] tx_rot;
  logic [7:0] ty_rot;
  logic       zone_left;
  logic       zone_right;
  logic       zone_top;
  logic       zone_bottom;
  logic       touch_dec;
  logic       touch_inc;
  logic       touch_center;
  logic       touch_rise;
  logic       touch_fall;
  uid_cal_st_t cal_st_r;

  assign tx_rot = touch_rotate ? touch_y : touch_x; // R19
  assign ty_rot = touch_rotate ? touch_x : touch_y; // R19

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_r       <= 8'h0;
      ty_r       <= 8'h0;
      tvalid_r   <= 1'b0;
      tvalid_q_r <= 1'b0;
    end else begin
      tx_r       <= touch_flip_x ? 8'(`UID_SCR_W_PX - 1) - tx_rot : tx_rot; // R19
      ty_r       <= touch_flip_y ? 8'(`UID_SCR_H_PX - 1) - ty_rot : ty_rot; // R19
      tvalid_r   <= touch_valid;
      tvalid_q_r <= tvalid_r;
    end
  end

  assign zone_left   = tx_r < 8'(`UID_EDGE_CHARS * `UID_CHAR_W_PX); // R11
  assign zone_right  = tx_r >= 8'((`UID_SCR_CHARS - `UID_EDGE_CHARS) * `UID_CHAR_W_PX); // R11
  assign zone_top    = ty_r < 8'(`UID_EDGE_LINES * `UID_LINE_H_PX); // R11
  assign zone_bottom = ty_r >= 8'((`UID_SCR_LINES - `UID_EDGE_LINES) * `UID_LINE_H_PX); // R11
  assign touch_rise  = tvalid_r & ~tvalid_q_r;
  assign touch_fall  = ~tvalid_r & tvalid_q_r;

  // Bars are dead while calibrating, the touch belongs to the marker
  assign touch_dec = tvalid_r & (cal_st_r == UID_C_IDLE) & (zone_left | zone_top); // R12
  assign touch_inc = tvalid_r & (cal_st_r == UID_C_IDLE) & ~touch_dec &
                     (zone_right | zone_bottom); // R12
  assign touch_center = tvalid_r & (cal_st_r == UID_C_IDLE) & ~touch_dec & ~touch_inc; // R11

  // ----------------------------------------------------------------
  // Key classification
  // ----------------------------------------------------------------
  uid_key_st_t key_st_r;
  logic [11:0] key_cnt_r;
  logic        powerup_r;
  logic        press;

  assign press = key_db_q_r | touch_center; // R14

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_st_r   <= UID_K_IDLE;
      key_cnt_r  <= 12'h0;
      powerup_r  <= 1'b1;
      key_short  <= 1'b0;
      key_long   <= 1'b0;
      key_double <= 1'b0;
      key_vlong  <= 1'b0;
    end else begin
      key_short  <= 1'b0;
      key_long   <= 1'b0;
      key_double <= 1'b0;
      key_vlong  <= 1'b0;
      if (tick && key_cnt_r != 12'hfff) begin
        key_cnt_r <= key_cnt_r + 12'h1;
      end
      unique case (key_st_r)
        UID_K_IDLE: begin
          // Key held from reset is still in debounce here
          if (!powerup_r) begin
            key_cnt_r <= 12'h0;
          end
          if (press) begin
            key_st_r <= UID_K_DOWN;
          end else if (key_cnt_r > 12'(`UID_DB_TICKS)) begin
            powerup_r <= 1'b0; // R21
          end
        end
        UID_K_DOWN: begin
          if (!press) begin
            key_cnt_r <= 12'h0;
            powerup_r <= 1'b0;
            if (powerup_r && key_cnt_r >= 12'(`UID_VLONG_TICKS)) begin
              key_vlong <= 1'b1; // R21
              key_st_r  <= UID_K_IDLE;
            end else if (key_cnt_r > 12'(`UID_LONG_TICKS)) begin
              key_long <= 1'b1; // R01
              key_st_r <= UID_K_IDLE;
            end else begin
              key_st_r <= UID_K_GAP;
            end
          end
        end
        UID_K_GAP: begin
          if (press) begin
            key_st_r <= UID_K_DOWN2; // R02
          end else if (key_cnt_r >= 12'(`UID_DCLICK_TICKS)) begin
            key_short <= 1'b1; // R01
            key_st_r  <= UID_K_IDLE;
          end
        end
        UID_K_DOWN2: begin
          if (!press) begin
            key_double <= 1'b1; // R02
            key_st_r   <= UID_K_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Quadrature decoding and velocity
  // ----------------------------------------------------------------
  logic [1:0]  ab_prev_r;
  logic [1:0]  ab;
  logic        one_edge;
  logic        dir_up;
  logic        pulse_dir_r;
  logic [2:0]  pulse_cnt_r;
  logic [2:0]  pulse_nxt;
  logic        enc_step;
  logic        enc_step_up;
  logic [9:0]  gap_r;
  logic [1:0]  fast_cnt_r;
  logic [17:0] gap_scaled;
  uid_grade_t  enc_grade;
  logic [1:0]  fast_nxt;

  assign ab        = db[2:1];
  assign one_edge  = ^(ab ^ ab_prev_r);
  assign dir_up    = ab_prev_r[0] ^ ab[1]; // R08
  assign pulse_nxt = (dir_up == pulse_dir_r) ? pulse_cnt_r + 3'h1 : 3'h1; // R04
  assign enc_step  = one_edge & (pulse_nxt >= enc_pulses); // R04
  assign enc_step_up = dir_up;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ab_prev_r   <= 2'h0;
      pulse_dir_r <= 1'b0;
      pulse_cnt_r <= 3'h0;
    end else begin
      ab_prev_r <= ab;
      if (one_edge) begin
        pulse_dir_r <= dir_up;
        pulse_cnt_r <= enc_step ? 3'h0 : pulse_nxt; // R04
      end
    end
  end

  // Finer encoders grade lower
  assign gap_scaled = 18'(gap_r) * 18'(enc_steps); // R05
  assign fast_nxt   = (fast_cnt_r == 2'h2) ? 2'h2 : fast_cnt_r + 2'h1;

  always_comb begin
    enc_grade = UID_GRADE_LOW;
    if (gap_r >= 10'(`UID_STEP_GAP_TICKS)) begin
      enc_grade = UID_GRADE_LOW; // R07
    end else if (gap_scaled < `UID_VEL_FAST_TH) begin
      enc_grade = (fast_nxt == 2'h2) ? UID_GRADE_HIGH : UID_GRADE_MID; // R07
    end else if (gap_scaled < `UID_VEL_MID_TH) begin
      enc_grade = UID_GRADE_MID; // R06
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r      <= 10'(`UID_STEP_GAP_TICKS);
      fast_cnt_r <= 2'h0;
    end else if (enc_step) begin
      gap_r <= 10'h0; // R06
      if (gap_r < 10'(`UID_STEP_GAP_TICKS) && gap_scaled < `UID_VEL_FAST_TH) begin
        fast_cnt_r <= fast_nxt; // R07
      end else begin
        fast_cnt_r <= 2'h0;
      end
    end else if (tick && gap_r < 10'(`UID_STEP_GAP_TICKS)) begin
      gap_r <= gap_r + 10'h1;
    end
  end

  // ----------------------------------------------------------------
  // Hold-to-accelerate for buttons and edge bars
  // ----------------------------------------------------------------
  logic       hold_up;
  logic       hold_dn;
  logic       hold_act_r;
  logic [8:0] rep_cnt_r;
  uid_grade_t hold_grade_r;
  logic       hold_step;
  logic       hold_up_r;

  assign hold_up   = db[3] | touch_inc; // R09
  assign hold_dn   = db[4] | touch_dec; // R09
  assign hold_step = ((hold_up | hold_dn) & ~hold_act_r) |
                     (hold_act_r & tick & rep_cnt_r == 9'(`UID_REPEAT_TICKS - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_act_r   <= 1'b0;
      hold_up_r    <= 1'b0;
      rep_cnt_r    <= 9'h0;
      hold_grade_r <= UID_GRADE_LOW;
    end else if (!(hold_up | hold_dn)) begin
      hold_act_r   <= 1'b0;
      rep_cnt_r    <= 9'h0;
      hold_grade_r <= UID_GRADE_LOW;
    end else if (!hold_act_r) begin
      hold_act_r <= 1'b1;
      hold_up_r  <= hold_up;
    end else if (tick) begin
      if (rep_cnt_r == 9'(`UID_REPEAT_TICKS - 1)) begin
        rep_cnt_r <= 9'h0;
        if (hold_grade_r != UID_GRADE_HIGH) begin
          hold_grade_r <= uid_grade_t'(hold_grade_r + 2'h1); // R10 R13
        end
      end else begin
        rep_cnt_r <= rep_cnt_r + 9'h1;
      end
    end
  end

  // Encoder wins a clash; hold repeats anyway
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_up     <= 1'b0;
      step_down   <= 1'b0;
      speed_grade <= UID_GRADE_LOW;
    end else begin
      step_up   <= 1'b0;
      step_down <= 1'b0;
      if (enc_step) begin
        step_up     <= enc_step_up; // R08
        step_down   <= ~enc_step_up;
        speed_grade <= enc_grade; // R06
      end else if (hold_step) begin
        step_up     <= hold_act_r ? hold_up_r : hold_up; // R12
        step_down   <= hold_act_r ? ~hold_up_r : ~hold_up;
        speed_grade <= hold_grade_r; // R13
      end
    end
  end

  // ----------------------------------------------------------------
  // Cursor and key hint
  // ----------------------------------------------------------------
  logic [8:0] blink_cnt_r;
  logic       blink_r;
  logic       hint;

  assign hint = show_key_hint_text & key_hint_avail;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt_r <= 9'h0;
      blink_r     <= 1'b0;
    end else if (tick) begin
      if (blink_cnt_r == 9'(`UID_BLINK_TICKS - 1)) begin
        blink_cnt_r <= 9'h0;
        blink_r     <= ~blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 9'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cursor_on   <= 1'b0;
      key_hint_on <= 1'b0;
    end else begin
      key_hint_on <= wait_key & (wait_mode != UID_WAIT_NONE) & hint;
      cursor_on   <= wait_key & ~hint & ((wait_mode == UID_WAIT_MORE) |
                     ((wait_mode == UID_WAIT_RESUME) & blink_r)); // R03
    end
  end

  // ----------------------------------------------------------------
  // Touch calibration
  // ----------------------------------------------------------------
  logic       boot_r;
  logic [1:0] attempt_r;

  assign cal_active         = (cal_st_r != UID_C_IDLE);
  assign marker_top_right   = (cal_st_r == UID_C_PT1);
  assign marker_bottom_left = (cal_st_r == UID_C_PT2);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_st_r  <= UID_C_IDLE;
      boot_r    <= 1'b1;
      attempt_r <= 2'h0;
      raw_show  <= 1'b0;
      raw_x     <= 8'h0;
      raw_y     <= 8'h0;
      cal_done  <= 1'b0;
      cal_fail  <= 1'b0;
      cal_abort <= 1'b0;
    end else begin
      boot_r    <= 1'b0;
      cal_done  <= 1'b0;
      cal_fail  <= 1'b0;
      cal_abort <= 1'b0;
      if (cal_active && key_rise) begin
        cal_st_r  <= UID_C_IDLE; // R18
        raw_show  <= 1'b0;
        cal_abort <= 1'b1;
      end else begin
        unique case (cal_st_r)
          UID_C_IDLE: begin
            if ((boot_r && !cal_stored) || cal_start) begin
              cal_st_r  <= UID_C_PT1; // R15
              attempt_r <= 2'h1;
              raw_show  <= 1'b0;
            end
          end
          UID_C_PT1, UID_C_PT2: begin
            if (touch_rise) begin
              raw_x    <= touch_x; // R16
              raw_y    <= touch_y;
              raw_show <= 1'b1;
              cal_st_r <= (cal_st_r == UID_C_PT1) ? UID_C_RAW1 : UID_C_RAW2;
            end
          end
          UID_C_RAW1: begin
            if (touch_fall) begin
              cal_st_r <= UID_C_PT2; // R16
            end
          end
          UID_C_RAW2: begin
            if (touch_fall) begin
              cal_st_r <= UID_C_EVAL;
            end
          end
          UID_C_EVAL: begin
            if (cal_check_valid) begin
              if (cal_check_ok) begin
                cal_done <= 1'b1;
                cal_st_r <= UID_C_IDLE;
              end else if (attempt_r < `UID_CAL_ATTEMPTS) begin
                attempt_r <= attempt_r + 2'h1; // R17
                raw_show  <= 1'b0;
                cal_st_r  <= UID_C_PT1;
              end else begin
                cal_fail <= 1'b1; // R17
                cal_st_r <= UID_C_IDLE;
              end
            end
          end
          default: cal_st_r <= UID_C_IDLE;
        endcase
      end
    end
  end

endmodule

//--- sim/uid_top_properties.sv
/*
  Port checker of uid_top.
  Assumes binding into uid_top.
*/
`timescale 1ns/1ps

module uid_top_properties
  import uid_pkg::*;
#(
  parameter int TICK_CYCLES = 10
)
(
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      test_key,
  input wire logic      cal_stored,
  input wire logic      wait_key,
  input wire uid_wait_t wait_mode,
  input wire logic      show_key_hint_text,
  input wire logic      key_hint_avail,
  input wire logic      key_short,
  input wire logic      key_long,
  input wire logic      key_double,
  input wire logic      key_hw_pressed,
  input wire logic      step_up,
  input wire logic      step_down,
  input wire logic      cursor_on,
  input wire logic      key_hint_on,
  input wire logic      cal_active,
  input wire logic      marker_top_right,
  input wire logic      marker_bottom_left,
  input wire logic      cal_abort
);
  // ----------
  // Helper
  // ----------
  // Twice the worst release debounce
  localparam int LIM = 6 * TICK_CYCLES + 4;
  int low_n_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_n_r <= 0;
    end else begin
      low_n_r <= test_key ? 0 : low_n_r + int'(low_n_r < LIM);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------
  // Properties
  // ----------
  property p_key_one; key_long |=> !key_long; endproperty
  a_key_one: assert property (p_key_one)
    else $error("long pulse too wide");
  property p_key_excl; key_double |-> !key_short && !key_long; endproperty
  a_key_excl: assert property (p_key_excl)
    else $error("double with other class");
  property p_cur_hint; cursor_on |-> !key_hint_on; endproperty
  a_cur_hint: assert property (p_cur_hint)
    else $error("cursor with hint");
  property p_hint;
    key_hint_on |-> $past(wait_key && show_key_hint_text && key_hint_avail
                          && wait_mode != UID_WAIT_NONE);
  endproperty
  a_hint: assert property (p_hint)
    else $error("hint without cause");
  property p_dir; step_up |-> !step_down; endproperty
  a_dir: assert property (p_dir)
    else $error("two directions");
  property p_boot; $fell(rst) && !cal_stored |=> cal_active && marker_top_right; endproperty
  a_boot: assert property (p_boot)
    else $error("no boot calibration");
  property p_marker; marker_top_right |-> cal_active && !marker_bottom_left; endproperty
  a_marker: assert property (p_marker)
    else $error("bad marker");
  property p_abort; cal_abort |=> !cal_active && !marker_bottom_left; endproperty
  a_abort: assert property (p_abort)
    else $error("abort ignored");
  property p_hw; low_n_r >= LIM |-> !key_hw_pressed; endproperty
  a_hw: assert property (p_hw)
    else $error("hardware key without key");
endmodule

bind uid_top uid_top_properties #(.TICK_CYCLES(TICK_CYCLES)) i_uid_top_properties (.*);

//--- sim/uid_far.sv
/*
  Far side: test key, encoder, buttons, touch panel.
  Assumes calls from one bench process, off the edge.
*/
`timescale 1ns/1ps

module uid_far #(
  parameter int TK = 10
)
(
  input  wire logic clk,
  output logic       test_key,
  output logic       enc_a,
  output logic       enc_b,
  output logic       inc_btn_n,
  output logic       dec_btn_n,
  output logic       touch_valid,
  output logic [7:0] touch_x,
  output logic [7:0] touch_y
);
  initial begin
    {test_key, enc_a, enc_b, touch_valid, inc_btn_n, dec_btn_n, touch_x, touch_y} = 22'h030000;
  end

  task automatic w(int n);
    repeat (n * TK) @(posedge clk);
    #1;
  endtask

  task automatic press(int t);
    test_key = 1'b1;
    w(t);
    test_key = 1'b0;
    w(10);
  endtask

  // Up turn: b moves while a equals b
  task automatic turn(bit up, int n);
    repeat (n) begin
      if ((enc_a == enc_b) == up) enc_b = ~enc_b;
      else enc_a = ~enc_a;
      w(8);
    end
  endtask

  // Pull-ups: released reads high
  task automatic hold(bit inc, int t);
    if (inc) inc_btn_n = 1'b0;
    else dec_btn_n = 1'b0;
    w(t);
    {inc_btn_n, dec_btn_n} = 2'h3;
    w(10);
  endtask

  task automatic touch(logic [7:0] x, logic [7:0] y, int t);
    {touch_x, touch_y} = {x, y};
    touch_valid = 1'b1;
    w(t);
    touch_valid = 1'b0;
    // Garble stale coordinates
    {touch_x, touch_y} = ~{x, y};
    w(8);
  endtask
endmodule

//--- sim/uid_top_tb.sv
/*
  Self-checking bench of uid_top.
  Assumes uid_far as the far side.
*/
`timescale 1ns/1ps

module uid_top_tb
  import uid_pkg::*;
;
  localparam int TK = 10;
  logic       clk;
  logic       rst = 1'b1;
  logic [2:0] enc_pulses = 3'h4;
  logic [7:0] enc_steps = 8'h04;
  logic       touch_flip_x = 1'b0, touch_flip_y = 1'b0, touch_rotate = 1'b0;
  logic       cal_stored = 1'b0, cal_start = 1'b0;
  logic       cal_check_valid = 1'b0, cal_check_ok = 1'b0;
  logic       wait_key = 1'b0, show_key_hint_text = 1'b0, key_hint_avail = 1'b0;
  uid_wait_t  wait_mode = UID_WAIT_NONE;
  logic       test_key, enc_a, enc_b, inc_btn_n, dec_btn_n, touch_valid;
  logic [7:0] touch_x, touch_y, raw_x, raw_y;
  logic       key_short, key_long, key_double, key_hw_pressed, step_up, step_down;
  uid_grade_t speed_grade, g;
  logic       cursor_on, key_hint_on, cal_active, marker_top_right;
  logic       marker_bottom_left, cal_fail, cal_abort, key_vlong, raw_show, cal_done;
  int         n_mismatch = 0, checked = 0, nu = 0, nd = 0, ns = 0;
  int         nl = 0, n2 = 0, nf = 0, na = 0, nv = 0, nc = 0;

  uid_top #(.TICK_CYCLES(TK)) i_uid_top (.*);
  uid_far #(.TK(TK)) i_uid_far (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------
  // Event counters
  // ----------
  always @(posedge clk) begin
    nu += step_up;
    nd += step_down;
    ns += key_short;
    nl += key_long;
    n2 += key_double;
    nf += cal_fail;
    na += cal_abort;
    nv += key_vlong;
    nc += cal_done;
    if (step_up | step_down) g = speed_grade;
  end

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic w(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_mismatch++;
    print_verdict();
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    int u0, d0, p;
    logic c;
    logic [7:0] zx [7], zy [7];
    logic [2:0] zm [7];
    logic [1:0] ze [7];
    void'($urandom(23729));
    enc_pulses = ($urandom % 2) ? 3'h4 : 3'h2;
    p = $urandom % 24;
    w(2);
    rst = 1'b0;
    w(3);
    chk(cal_active, 1);
    for (int r = 0; r < 4; r++) begin
      cal_start = (r == 3);
      i_uid_far.touch(8'h78, 8'h04, 20);
      chk(raw_x, 8'h78);
      chk(raw_y, 8'h04);
      chk({raw_show, marker_bottom_left}, 3);
      i_uid_far.touch(8'h04, 8'h78, 20);
      {cal_check_valid, cal_check_ok, cal_start} = {1'b1, r == 3, 1'b0};
      w(1);
      cal_check_valid = 1'b0;
      w(2);
      chk(marker_top_right, r < 2);
    end
    chk(nf, 1);
    chk(nc, 1);
    cal_start = 1'b1;
    w(1);
    cal_start = 1'b0;
    w(2);
    i_uid_far.press(20);
    chk(na, 1);
    chk(cal_active, 0);
    w(700 * TK);
    ns = 0;
    // Code: 2 up, 1 down, 0 key press
    zx = '{p[7:0], 8'h68, 8'h40, 8'h40, 8'h40, p[7:0], 8'h40};
    zy = '{8'h40, 8'h40, 8'h1f, 8'h1f, 8'h60, 8'h40, 8'h64};
    zm = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h1, 3'h4};
    ze = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 7; i++) begin
      {touch_rotate, touch_flip_y, touch_flip_x} = zm[i];
      w(2);
      u0 = nu;
      d0 = nd;
      i_uid_far.touch(zx[i], zy[i], 30);
      chk(8'((nu - u0) * 2 + nd - d0), ze[i]);
    end
    w(600 * TK);
    chk(ns, 1);
    i_uid_far.press(100);
    w(600 * TK);
    chk(ns, 2);
    i_uid_far.press(400);
    chk(nl, 1);
    i_uid_far.press(50);
    w(100 * TK);
    i_uid_far.press(50);
    w(600 * TK);
    chk(n2, 1);
    chk(ns, 2);
    for (int s = 0; s < 3; s++) begin
      u0 = nu;
      i_uid_far.turn(1, enc_pulses - 1);
      chk(nu - u0, 0);
      i_uid_far.turn(1, 1);
      chk(nu - u0, 1);
      chk(g, s);
    end
    enc_steps = 8'hc8;
    d0 = nd;
    i_uid_far.turn(0, enc_pulses);
    chk(nd - d0, 1);
    chk(g, UID_GRADE_LOW);
    u0 = nu;
    i_uid_far.hold(1, 800);
    chk(nu - u0, 4);
    chk(g, UID_GRADE_HIGH);
    d0 = nd;
    i_uid_far.hold(0, 100);
    chk(nd - d0, 1);
    chk(g, UID_GRADE_LOW);
    wait_key = 1'b1;
    wait_mode = UID_WAIT_MORE;
    w(3);
    chk(cursor_on, 1);
    {show_key_hint_text, key_hint_avail} = 2'h3;
    w(3);
    chk({cursor_on, key_hint_on}, 1);
    show_key_hint_text = 1'b0;
    wait_mode = UID_WAIT_RESUME;
    w(3);
    c = cursor_on;
    w(500 * TK);
    chk(cursor_on, !c);
    wait_mode = UID_WAIT_NONE;
    w(3);
    chk(cursor_on, 0);
    {rst, cal_stored} = 2'h3;
    fork
      i_uid_far.press(2100);
      #20 rst = 1'b0;
    join
    chk(cal_active, 0);
    chk(nv, 1);
    print_verdict();
  end
endmodule
